/* rtl/smbr_regs.sv */
// Purpose: Host data, block array and slave event enable registers of a bus controller.
// Assumes: Register port on ref_clk; link engine on link_clk, requests crossed by a toggle handshake, slave accesses by a toggle.
// Notes: The link side moves bytes through the array: stores cross by the toggle handshake, fetches read it directly on link_clk.
`timescale 1ns/1ps
module smbr_regs (
  input wire logic ref_clk,                  // Register clock.
  input wire logic rst_b,                    // Asynchronous reset, active low.
  input wire logic [3:0] reg_addr,           // Register offset.
  input wire logic reg_wr,                   // Write strobe, one cycle.
  input wire logic reg_rd,                   // Read strobe, one cycle.
  input wire logic [7:0] reg_wdata,          // Write data.
  output logic [7:0] reg_rdata,              // Read data, registered.
  output logic start_pulse,                  // Launch pulse to engine.
  output smbr_pkg::smbr_job_t job,           // Programmed transaction.
  output logic [5:0] block_count,            // Block transfer count.
  input wire logic link_clk,                 // Link engine clock.
  input wire logic link_rst_b,               // Link reset, active low.
  input wire logic link_rd_first,            // Received first byte strobe.
  input wire logic link_rd_second,           // Received second byte strobe.
  input wire logic link_blk_first,           // Block transfer begin strobe.
  input wire logic link_blk_wr,              // Store received block byte.
  input wire logic link_blk_rd,              // Fetch block byte to send.
  input wire logic [7:0] link_rx_byte,       // Received byte.
  output logic [7:0] link_tx_byte,           // Block byte to send.
  output logic link_busy,                    // Previous link request pending.
  input wire logic alert_b,                  // Bus alert pin, active low.
  input wire logic slv_valid,                // Slave access seen, link pulse.
  input wire smbr_pkg::smbr_slv_t slv_info,  // Slave access details.
  output logic wake_event                    // Event pulse, ref_clk domain.
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] addr_ff, data0_ff, data1_ff, cmd_ff, slvctl_ff, mir1_ff, mir2_ff, cmatch_ff;
  logic [2:0] prot_ff;
  logic [15:0] evmask_ff;
  logic [4:0] idx_ff;
  logic [7:0] arr_ff [smbr_pkg::BLOCK_DEPTH];
  logic [7:0] rdata_ff;
  logic start_ff;

  // Link request captured on link_clk, moved to ref_clk by toggle.
  logic [2:0] lk_kind_ff;
  logic [7:0] lk_byte_ff;
  logic lk_tog_ff, s1_ff, s2_ff, s3_ff;
  logic ack_tog_ff, a1_ff, a2_ff;
  logic [2:0] alert_sync_ff;
  logic sv_tog_ff, v1_ff, v2_ff, v3_ff;
  smbr_pkg::smbr_slv_t sv_ff;
  logic [4:0] lidx_ff;
  logic [7:0] tx_ff;
  logic wake_ff;

  wire wr_addr = reg_wr && reg_addr == smbr_pkg::OFS_TARGET_ADDR;
  wire wr_d0 = reg_wr && reg_addr == smbr_pkg::OFS_FIRST_DATA;
  wire wr_d1 = reg_wr && reg_addr == smbr_pkg::OFS_SECOND_DATA;
  wire wr_ctl = reg_wr && reg_addr == smbr_pkg::OFS_HOST_CTRL;
  wire acc_blk = (reg_wr || reg_rd) && reg_addr == smbr_pkg::OFS_BLOCK_PORT;
  wire rd_ctl = reg_rd && reg_addr == smbr_pkg::OFS_HOST_CTRL;
  // Write strobes of the registers that only software changes.
  wire wr_cmd = reg_wr && reg_addr == smbr_pkg::OFS_HOST_CMD;
  wire wr_slvctl = reg_wr && reg_addr == smbr_pkg::OFS_SLAVE_CTRL;
  wire wr_mir1 = reg_wr && reg_addr == smbr_pkg::OFS_MIRROR1;
  wire wr_mir2 = reg_wr && reg_addr == smbr_pkg::OFS_MIRROR2;
  wire wr_cmatch = reg_wr && reg_addr == smbr_pkg::OFS_CMD_MATCH;
  wire wr_mask_lo = reg_wr && reg_addr == smbr_pkg::OFS_EVT_MASK_LO;
  wire wr_mask_hi = reg_wr && reg_addr == smbr_pkg::OFS_EVT_MASK_HI;
  wire link_evt = s2_ff ^ s3_ff;
  wire prot_ok = reg_wdata[4:2] != 3'h4 && reg_wdata[4:2] != 3'h6 && reg_wdata[4:2] != 3'h7;

  // ----------------------------------------------------------------
  // Link side: capture a request and toggle it across
  // ----------------------------------------------------------------
  wire lk_req = link_rd_first || link_rd_second || link_blk_first || link_blk_wr;
  assign link_busy = lk_tog_ff != a2_ff;
  always_ff @(posedge link_clk or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      lk_tog_ff <= 1'b0;
      lk_kind_ff <= 3'h0;
      lk_byte_ff <= smbr_pkg::RST_BYTE;
      a1_ff <= 1'b0;
      a2_ff <= 1'b0;
      lidx_ff <= smbr_pkg::IDX_ZERO;
      tx_ff <= smbr_pkg::RST_BYTE;
    end
    else
    begin
      a1_ff <= ack_tog_ff;
      a2_ff <= a1_ff;
      if (lk_req && !link_busy)
      begin
        lk_tog_ff <= ~lk_tog_ff;
        lk_kind_ff <= {link_blk_wr, link_rd_second, link_rd_first};
        lk_byte_ff <= link_rx_byte;
      end
      // A fetch together with the block start sends byte zero and moves on to one.
      if (link_blk_first)
        lidx_ff <= link_blk_rd ? 5'h01 : smbr_pkg::IDX_ZERO;
      else if (link_blk_rd)
        lidx_ff <= lidx_ff + 5'h01;
      // Array is read directly on link_clk with no crossing; nothing here holds it stable.
      if (link_blk_rd)
        tx_ff <= arr_ff[link_blk_first ? smbr_pkg::IDX_ZERO : lidx_ff];
    end
  end
  assign link_tx_byte = tx_ff;

  // Slave access details held on link_clk, flagged by toggle.
  always_ff @(posedge link_clk or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      sv_tog_ff <= 1'b0;
      sv_ff <= '0;
    end
    else if (slv_valid)
    begin
      sv_tog_ff <= ~sv_tog_ff;
      sv_ff <= slv_info;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers into ref_clk
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      ack_tog_ff <= 1'b0;
      v1_ff <= 1'b0;
      v2_ff <= 1'b0;
      v3_ff <= 1'b0;
      alert_sync_ff <= 3'h7;
    end
    else
    begin
      s1_ff <= lk_tog_ff;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      ack_tog_ff <= s3_ff;
      v1_ff <= sv_tog_ff;
      v2_ff <= v1_ff;
      v3_ff <= v2_ff;
      alert_sync_ff <= {alert_sync_ff[1:0], alert_b};
    end
  end

  // ----------------------------------------------------------------
  // Slave event generation
  // ----------------------------------------------------------------
  wire alert_fall = alert_sync_ff[2] && !alert_sync_ff[1];
  wire sv_new = v2_ff ^ v3_ff;
  wire host_hit = sv_ff.addr == smbr_pkg::HOST_SLAVE_ADDR && sv_ff.cmd == cmatch_ff
                  && |(sv_ff.data & evmask_ff);
  wire ev_alert = alert_fall && slvctl_ff[smbr_pkg::BIT_ALERT_EN];
  wire ev_m2 = sv_new && slvctl_ff[smbr_pkg::BIT_MIRROR2_EN]
               && sv_ff.addr == mir2_ff[7:1];
  wire ev_m1 = sv_new && slvctl_ff[smbr_pkg::BIT_MIRROR1_EN]
               && sv_ff.addr == mir1_ff[7:1];
  wire ev_slv = sv_new && slvctl_ff[smbr_pkg::BIT_SLAVE_EN] && host_hit;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      wake_ff <= 1'b0;
    else
      wake_ff <= ev_alert || ev_m2 || ev_m1 || ev_slv;
  end
  assign wake_event = wake_ff;

  // ----------------------------------------------------------------
  // Register writes and link updates
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_ff <= smbr_pkg::RST_BYTE;
      data0_ff <= smbr_pkg::RST_BYTE;
      data1_ff <= smbr_pkg::RST_BYTE;
      cmd_ff <= smbr_pkg::RST_BYTE;
      slvctl_ff <= smbr_pkg::RST_BYTE;
      mir1_ff <= smbr_pkg::RST_BYTE;
      mir2_ff <= smbr_pkg::RST_BYTE;
      cmatch_ff <= smbr_pkg::RST_BYTE;
      evmask_ff <= smbr_pkg::RST_WORD;
      prot_ff <= smbr_pkg::PROT_QUICK;
      start_ff <= 1'b0;
    end
    else
    begin
      start_ff <= wr_ctl && reg_wdata[smbr_pkg::BIT_START];
      if (wr_addr)
        addr_ff <= reg_wdata;
      if (wr_d1)
        data1_ff <= reg_wdata;
      else if (link_evt && lk_kind_ff[1])
        data1_ff <= lk_byte_ff;
      if (wr_d0)
        data0_ff <= reg_wdata;
      else if (link_evt && lk_kind_ff[0])
        data0_ff <= lk_byte_ff;
      if (wr_ctl && prot_ok)
        prot_ff <= reg_wdata[4:2];
      if (wr_cmd)
        cmd_ff <= reg_wdata;
      if (wr_slvctl)
        slvctl_ff <= reg_wdata & smbr_pkg::SLAVE_CTRL_MASK;
      if (wr_mir1)
        mir1_ff <= reg_wdata;
      if (wr_mir2)
        mir2_ff <= reg_wdata;
      if (wr_cmatch)
        cmatch_ff <= reg_wdata;
      if (wr_mask_lo)
        evmask_ff[7:0] <= reg_wdata;
      if (wr_mask_hi)
        evmask_ff[15:8] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Block array and index pointer
  // ----------------------------------------------------------------
  // A link block start zeroes the index in the same way as a host control read.
  logic [4:0] nxt_idx;
  always_comb
  begin
    nxt_idx = idx_ff;
    if (rd_ctl || (link_evt && lk_kind_ff[2] == 1'b0 && lk_kind_ff == 3'h0))
      nxt_idx = smbr_pkg::IDX_ZERO;
    else if (acc_blk)
      nxt_idx = idx_ff + 5'h01;
    else if (link_evt && lk_kind_ff[2])
      nxt_idx = idx_ff + 5'h01;
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      idx_ff <= smbr_pkg::IDX_ZERO;
    else
      idx_ff <= nxt_idx;
  end

  genvar gi;
  generate
    for (gi = 0; gi < smbr_pkg::BLOCK_DEPTH; gi++)
    begin : g_arr
      wire hit = idx_ff == 5'(gi);
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          arr_ff[gi] <= smbr_pkg::RST_BYTE;
        else if (reg_wr && acc_blk && hit)
          arr_ff[gi] <= reg_wdata;
        else if (link_evt && lk_kind_ff[2] && hit)
          arr_ff[gi] <= lk_byte_ff;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr)
      smbr_pkg::OFS_HOST_CTRL: rd_mux = {3'h0, prot_ff, 2'h0};
      smbr_pkg::OFS_HOST_CMD: rd_mux = cmd_ff;
      smbr_pkg::OFS_TARGET_ADDR: rd_mux = addr_ff;
      smbr_pkg::OFS_FIRST_DATA: rd_mux = data0_ff;
      smbr_pkg::OFS_SECOND_DATA: rd_mux = data1_ff;
      smbr_pkg::OFS_BLOCK_PORT: rd_mux = arr_ff[idx_ff];
      smbr_pkg::OFS_SLAVE_CTRL: rd_mux = slvctl_ff;
      smbr_pkg::OFS_MIRROR1: rd_mux = mir1_ff;
      smbr_pkg::OFS_MIRROR2: rd_mux = mir2_ff;
      smbr_pkg::OFS_CMD_MATCH: rd_mux = cmatch_ff;
      smbr_pkg::OFS_EVT_MASK_LO: rd_mux = evmask_ff[7:0];
      smbr_pkg::OFS_EVT_MASK_HI: rd_mux = evmask_ff[15:8];
      default: rd_mux = smbr_pkg::RST_BYTE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= smbr_pkg::RST_BYTE;
    else if (reg_rd)
      rdata_ff <= rd_mux;
  end
  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Outputs to the transaction engine
  // ----------------------------------------------------------------
  assign start_pulse = start_ff;
  assign job.target_slave_addr = addr_ff[7:1];
  assign job.direction_bit = addr_ff[0];
  assign job.host_command_byte = cmd_ff;
  assign job.first_data_byte = data0_ff;
  assign job.second_data_byte = data1_ff;
  assign job.protocol_select = prot_ff;
  // The block count leaves on a flop, one cycle behind the job fields.
  logic [5:0] blk_cnt_ff;
  wire [5:0] nxt_blk_cnt = (prot_ff == smbr_pkg::PROT_BLOCK) ? data0_ff[5:0] : 6'h00;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      blk_cnt_ff <= '0;
    else
      blk_cnt_ff <= nxt_blk_cnt;
  end
  assign block_count = blk_cnt_ff;
endmodule : smbr_regs

/* shared/smbr_pkg.sv */
// Purpose: Constants and carrier types for the bus host data and slave enable registers.
// Assumes: Byte-wide register port at base plus offset.
// Notes: Offsets are byte offsets from the block's I/O base.
package smbr_pkg;
  localparam logic [3:0] OFS_HOST_CTRL = 4'h2;
  localparam logic [3:0] OFS_HOST_CMD = 4'h3;
  localparam logic [3:0] OFS_TARGET_ADDR = 4'h4;
  localparam logic [3:0] OFS_FIRST_DATA = 4'h5;
  localparam logic [3:0] OFS_SECOND_DATA = 4'h6;
  localparam logic [3:0] OFS_BLOCK_PORT = 4'h7;
  localparam logic [3:0] OFS_SLAVE_CTRL = 4'h8;
  localparam logic [3:0] OFS_MIRROR1 = 4'h9;
  localparam logic [3:0] OFS_MIRROR2 = 4'hA;
  localparam logic [3:0] OFS_CMD_MATCH = 4'hB;
  localparam logic [3:0] OFS_EVT_MASK_LO = 4'hC;
  localparam logic [3:0] OFS_EVT_MASK_HI = 4'hD;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int BLOCK_DEPTH = 32;
  localparam logic [4:0] IDX_ZERO = 5'h00;
  localparam int BIT_START = 6;
  localparam int BIT_ALERT_EN = 3;
  localparam int BIT_MIRROR2_EN = 2;
  localparam int BIT_MIRROR1_EN = 1;
  localparam int BIT_SLAVE_EN = 0;
  localparam logic [7:0] SLAVE_CTRL_MASK = 8'h0F;
  localparam logic [7:0] HOST_CTRL_MASK = 8'h1F;
  localparam logic [6:0] HOST_SLAVE_ADDR = 7'h10;
  localparam logic [2:0] PROT_QUICK = 3'h0;
  localparam logic [2:0] PROT_BYTE = 3'h1;
  localparam logic [2:0] PROT_BYTE_DATA = 3'h2;
  localparam logic [2:0] PROT_WORD_DATA = 3'h3;
  localparam logic [2:0] PROT_BLOCK = 3'h5;

  typedef struct packed {
    logic [6:0] target_slave_addr;
    logic direction_bit;
    logic [7:0] host_command_byte;
    logic [7:0] first_data_byte;
    logic [7:0] second_data_byte;
    logic [2:0] protocol_select;
  } smbr_job_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] cmd;
    logic [15:0] data;
  } smbr_slv_t;
endpackage : smbr_pkg

/* bench/smbr_regs_asserts.sv */
// Purpose: Port-level checks of the host data registers.
// Assumes: Job fields and read data registered one cycle after a strobe.
// Notes: Register-clock domain only.
`timescale 1ns/1ps
module smbr_regs_asserts (
  input wire logic ref_clk,              // Register clock.
  input wire logic rst_b,                // Reset, active low.
  input wire logic [3:0] reg_addr,       // Offset.
  input wire logic reg_wr,               // Write strobe.
  input wire logic reg_rd,               // Read strobe.
  input wire logic [7:0] reg_wdata,      // Write data.
  input wire logic [7:0] reg_rdata,      // Read data.
  input wire logic start_pulse,          // Launch pulse.
  input wire smbr_pkg::smbr_job_t job,   // Programmed job.
  input wire logic [5:0] block_count     // Block count.
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  wire wr_ctrl = reg_wr && reg_addr == smbr_pkg::OFS_HOST_CTRL;
  wire rd_ctrl = reg_rd && reg_addr == smbr_pkg::OFS_HOST_CTRL;
  wire is_blk = job.protocol_select == smbr_pkg::PROT_BLOCK;
  sequence launch_write;
    wr_ctrl && reg_wdata[smbr_pkg::BIT_START];
  endsequence
  start_pulse_a: assert property (launch_write |=> start_pulse)
    else $error("start pulse missing");
  start_cause_a: assert property (start_pulse |-> $past(wr_ctrl && reg_wdata[6]))
    else $error("start pulse without launch write");
  ctrl_read_a: assert property (rd_ctrl |=> reg_rdata == {3'h0, job.protocol_select, 2'h0})
    else $error("host control read value wrong");
  slv_read_a: assert property (reg_rd && reg_addr == smbr_pkg::OFS_SLAVE_CTRL |=>
    reg_rdata[7:4] == 4'h0) else $error("slave control upper bits set");
  addr_load_a: assert property (reg_wr && reg_addr == smbr_pkg::OFS_TARGET_ADDR |=>
    {job.target_slave_addr, job.direction_bit} == $past(reg_wdata)) else $error("address");
  cmd_load_a: assert property (reg_wr && reg_addr == smbr_pkg::OFS_HOST_CMD |=>
    job.host_command_byte == $past(reg_wdata)) else $error("command byte");
  data_load_a: assert property (reg_wr && reg_addr == smbr_pkg::OFS_SECOND_DATA |=>
    job.second_data_byte == $past(reg_wdata)) else $error("second data byte");
  prot_keep_a: assert property (wr_ctrl && reg_wdata[4:2] inside {3'h4, 3'h6, 3'h7} |=>
    $stable(job.protocol_select)) else $error("reserved protocol taken");
  blk_count_a: assert property (is_blk && $stable(job) |->
    block_count == job.first_data_byte[5:0]) else $error("block count wrong");
  blk_zero_a: assert property (!is_blk && $stable(job) |-> block_count == 6'h00)
    else $error("block count outside block");
endmodule : smbr_regs_asserts

/* bench/smbr_link_model.sv */
// Purpose: Far side of the link: slave devices and external masters.
// Assumes: Requests wait for link_busy low and last one link cycle.
// Notes: Released rx and slv_info show the inverse of the last value; lreq returns to zero.
`timescale 1ns/1ps
module smbr_link_model (
  input wire logic link_clk,            // Link clock.
  input wire logic link_busy,           // Crossing pending.
  output logic [4:0] lreq,              // First, second, blk start, blk store, blk fetch.
  output logic [7:0] rx,                // Received byte.
  output logic alert_b,                 // Alert pin, pulled up.
  output logic slv_valid,               // Slave access pulse.
  output smbr_pkg::smbr_slv_t slv_info  // Slave access details.
);
  initial
  begin
    lreq = 5'h00;
    rx = 8'hFF;
    alert_b = 1'b1;
    slv_valid = 1'b0;
    slv_info = '1;
  end
  task send(input int k, input logic [7:0] b);
    @(posedge link_clk);
    while (link_busy) @(posedge link_clk);
    lreq <= 5'(1 << k);
    rx <= b;
    @(posedge link_clk);
    lreq <= 5'h00;
    rx <= ~b;
    repeat (4) @(posedge link_clk);
  endtask : send
  task slv(input smbr_pkg::smbr_slv_t s);
    @(posedge link_clk);
    slv_valid <= 1'b1;
    slv_info <= s;
    @(posedge link_clk);
    slv_valid <= 1'b0;
    slv_info <= ~s;
    repeat (4) @(posedge link_clk);
  endtask : slv
  task alert();
    @(posedge link_clk);
    alert_b <= 1'b0;
    repeat (4) @(posedge link_clk);
    alert_b <= 1'b1;
    repeat (4) @(posedge link_clk);
  endtask : alert
endmodule : smbr_link_model

/* bench/smbr_regs_bench.sv */
// Purpose: Self-checking bench of the host data and slave enable registers.
// Assumes: Link model drives the link side; bench drives the register port.
// Notes: Events are counted from the start of each stimulus to the end of a fixed window after it.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); end end
module smbr_regs_bench;
  logic ref_clk, link_clk, rst_b, reg_wr, reg_rd, start_pulse, link_busy, wake_event;
  logic alert_b, slv_valid;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, link_tx_byte, rx;
  logic [5:0] block_count;
  logic [4:0] lreq;
  logic [2:0] cur;
  smbr_pkg::smbr_job_t job;
  smbr_pkg::smbr_slv_t slv_info;
  int n_errors, samples_checked, n_wake, cyc;
  initial
  begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    link_clk = 0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  smbr_regs DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .start_pulse(start_pulse),
    .job(job), .block_count(block_count), .link_clk(link_clk), .link_rst_b(rst_b),
    .link_rd_first(lreq[0]), .link_rd_second(lreq[1]), .link_blk_first(lreq[2]),
    .link_blk_wr(lreq[3]), .link_blk_rd(lreq[4]), .link_rx_byte(rx),
    .link_tx_byte(link_tx_byte), .link_busy(link_busy), .alert_b(alert_b),
    .slv_valid(slv_valid), .slv_info(slv_info), .wake_event(wake_event));
  smbr_link_model PEER (.link_clk(link_clk), .link_busy(link_busy), .lreq(lreq), .rx(rx),
    .alert_b(alert_b), .slv_valid(slv_valid), .slv_info(slv_info));
  task complete_run();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rdc
  task evc(input int b, input logic en);
    wr(smbr_pkg::OFS_SLAVE_CTRL, en ? 8'(1 << (b % 4)) : 8'h00);
    n_wake = 0;
    case (b)
      0: PEER.slv({7'h10, 8'h3C, 16'h0003});
      1: PEER.slv({7'h2A, 8'h11, 16'h0000});
      2: PEER.slv({7'h33, 8'h11, 16'h0000});
      3: PEER.alert();
      default: PEER.slv({7'h10, 8'h3C, 16'h0100});
    endcase
    repeat (60) @(posedge ref_clk);
    `CHK(n_wake != 0, en && b < 4)
  endtask : evc
  always @(posedge ref_clk)
  begin
    cyc++;
    if (wake_event === 1'b1) n_wake++;
    if (cyc == 30000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    rst_b = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int a = 4; a <= 8; a++) rdc(a[3:0], 8'h00);
    wr(4'h4, 8'hA5);
    wr(4'h5, 8'h3C);
    wr(4'h6, 8'h96);
    wr(4'h3, 8'h7E);
    #1 `CHK({job.target_slave_addr, job.direction_bit}, 8'hA5)
    `CHK({job.host_command_byte, job.first_data_byte, job.second_data_byte}, 24'h7E3C96)
    wr(4'h8, 8'hFF);
    rdc(4'h8, 8'h0F);
    $display("test registers done");
    rdc(4'h2, 8'h00);
    for (int i = 0; i < 33; i++) wr(4'h7, 8'(8'h40 + i));
    rdc(4'h2, 8'h00);
    for (int i = 0; i < 32; i++) rdc(4'h7, i == 0 ? 8'h60 : 8'(8'h40 + i));
    $display("test block array done");
    wr(4'h5, 8'h20);
    cur = 3'h0;
    for (int p = 0; p < 8; p++)
    begin
      wr(4'h2, {3'h2, p[2:0], 2'h0});
      #1 `CHK(start_pulse, 1'b1)
      if (!(p == 4 || p > 5)) cur = p[2:0];
      rdc(4'h2, {3'h0, cur, 2'h0});
    end
    `CHK(block_count, 6'h20)
    $display("test protocol done");
    PEER.send(0, 8'hC3);
    `CHK(link_busy, 1'b0)
    rdc(4'h5, 8'hC3);
    PEER.send(1, 8'h5A);
    rdc(4'h6, 8'h5A);
    PEER.send(2, 8'h00);
    PEER.send(3, 8'hD0);
    PEER.send(3, 8'hD1);
    rdc(4'h2, 8'h14);
    rdc(4'h7, 8'hD0);
    rdc(4'h7, 8'hD1);
    PEER.send(2, 8'h00);
    PEER.send(4, 8'h00);
    `CHK(link_tx_byte, 8'hD0)
    $display("test link done");
    wr(4'h9, {7'h2A, 1'b0});
    wr(4'hA, {7'h33, 1'b0});
    wr(4'hB, 8'h3C);
    wr(4'hC, 8'h01);
    wr(4'hD, 8'h00);
    for (int b = 0; b < 5; b++)
    begin
      evc(b, 1'b0);
      evc(b, 1'b1);
    end
    $display("test events done");
    complete_run();
  end
endmodule : smbr_regs_bench
bind smbr_regs smbr_regs_asserts u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .start_pulse(start_pulse), .job(job), .block_count(block_count));
